// ==== bench/cpu_bit_and_memory_ops_tb.sv ====
// self-checking bench for the bit and memory execution unit
module cpu_bit_and_memory_ops_tb import core_pkg::*;;
timeunit 1ns;
timeprecision 1ns;
logic sys_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0;
logic sw_wr = 1'b0, sw_rd = 1'b0;
op_t cmd_op = op_nop;
logic [4:0] cmd_reg = 5'h00;
logic [2:0] cmd_bit = 3'h0;
logic [5:0] cmd_io = 6'h15;
logic [7:0] ram_rdata = 8'h00, io_rdata = 8'h00, sw_wdata = 8'h00;
logic [3:0] sw_addr = 4'h0;
logic cmd_ready, cmd_done, ram_rd, ram_we, io_we, prog_we;
logic [15:0] ram_addr, prog_wdata, ra, pw;
logic [7:0] ram_wdata, io_wdata, sw_rdata, iw, rw;
logic [5:0] io_addr;
logic [23:0] prog_addr, pa;
int mismatches = 0, samples_checked = 0;
int rds = 0;
exec_core dut_u (.sys_clk, .rst, .cmd_valid, .cmd_op, .cmd_reg,
    .cmd_bit, .cmd_io, .cmd_ready, .cmd_done, .ram_addr, .ram_rd,
    .ram_we, .ram_wdata, .ram_rdata, .io_addr, .io_we, .io_wdata,
    .io_rdata, .prog_addr, .prog_we, .prog_wdata, .sw_addr,
    .sw_wdata, .sw_wr, .sw_rd, .sw_rdata);
always #25 sys_clk = ~sys_clk;
// ------------------------------------------------------------
// shared drivers
// ------------------------------------------------------------
task chk(string n, logic [23:0] e, logic [23:0] g);
    samples_checked++;
    if (g !== e) begin
        mismatches++;
        $display("wrong value %s expected %h seen %h", n, e, g);
    end
endtask : chk
// counts cycles from the accepting edge up to the done pulse
task op(op_t o, logic [4:0] r, logic [2:0] b, int n);
    int c;
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_op <= o;
    cmd_reg <= r;
    cmd_bit <= b;
    do @(posedge sys_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    c = 0;
    rds = 0;
    do begin
        @(negedge sys_clk);
        c++;
        if (ram_rd) rds++;
        if (io_we) iw = io_wdata;
        if (ram_we) begin
            rw = ram_wdata;
            ra = ram_addr;
        end
        if (prog_we) begin
            pw = prog_wdata;
            pa = prog_addr;
        end
    end while (cmd_done !== 1'b1 && c < 20);
    chk("cycles", 24'(n), 24'(c));
endtask : op
task ld(logic [4:0] r, logic [7:0] v);
    @(posedge sys_clk);
    io_rdata <= v;
    op(op_io_read, r, 3'h0, 2);
endtask : ld
task rg(logic [4:0] r, logic [7:0] e);
    op(op_io_write, r, 3'h0, 2);
    chk("reg", 24'(e), 24'(iw));
endtask : rg
task sw(logic [3:0] a, logic [7:0] d);
    @(posedge sys_clk);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge sys_clk);
    sw_wr <= 1'b0;
endtask : sw
task rd(logic [3:0] a, logic [7:0] e);
    @(posedge sys_clk);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge sys_clk);
    sw_rd <= 1'b0;
    @(negedge sys_clk);
    chk("sw_rdata", 24'(e), 24'(sw_rdata));
endtask : rd
// ------------------------------------------------------------
// scenarios
// ------------------------------------------------------------
task t_flags();
    for (int s = 0; s < 8; s++) begin
        op(op_flag_set, 5'h00, 3'(s), 2);
        rd(4'h0, 8'(1 << s));
        op(op_flag_clear, 5'h00, 3'(s), 2);
        rd(4'h0, 8'h00);
    end
    ld(5'h05, 8'h20);
    op(op_t_flag_store, 5'h05, 3'h5, 2);
    rd(4'h0, 8'h40);
    ld(5'h06, 8'h00);
    op(op_t_flag_load, 5'h06, 3'h0, 2);
    rg(5'h06, 8'h01);
    rd(4'h0, 8'h40);
    $display("t_flags done");
endtask : t_flags
task automatic t_shift();
    op_t ops[4] = '{op_shift_left_logical, op_shift_right_logical,
        op_shift_right_arith, op_nibble_swap};
    logic [7:0] ex[4] = '{8'h02, 8'h40, 8'hc0, 8'h18};
    op(op_flag_clear, 5'h00, 3'h6, 2);
    op(op_flag_set, 5'h00, 3'h0, 2);
    ld(5'h07, 8'h88);
    op(op_rotate_left_carry, 5'h07, 3'h0, 2);
    rg(5'h07, 8'h11);
    rd(4'h0, 8'h29);
    ld(5'h07, 8'h01);
    op(op_flag_clear, 5'h00, 3'h0, 2);
    op(op_rotate_right_carry, 5'h07, 3'h0, 2);
    rg(5'h07, 8'h00);
    rd(4'h0, 8'h2b);
    for (int i = 0; i < 4; i++) begin
        ld(5'h07, 8'h81);
        op(ops[i], 5'h07, 3'h0, 2);
        rg(5'h07, ex[i]);
    end
    @(posedge sys_clk);
    io_rdata <= 8'ha0;
    op(op_io_bit_set, 5'h00, 3'h1, 2);
    chk("io_wdata", 24'h0000a2, 24'(iw));
    chk("io_addr", 24'h000015, 24'(io_addr));
    op(op_io_bit_clear, 5'h00, 3'h7, 2);
    chk("io_wdata", 24'h000020, 24'(iw));
    $display("t_shift done");
endtask : t_shift
task automatic t_mem();
    op_t ops[4] = '{op_load_and_set, op_load_and_clear,
        op_load_and_toggle, op_memory_exchange};
    logic [7:0] mem[4] = '{8'h3c, 8'hf0, 8'h55, 8'h11};
    logic [7:0] wex[4] = '{8'h3f, 8'hc0, 8'ha5, 8'h55};
    sw(4'h1, 8'h10);
    sw(4'h2, 8'h00);
    ld(5'h08, 8'h0f);
    for (int i = 0; i < 4; i++) begin
        @(posedge sys_clk);
        ram_rdata <= mem[i];
        op(ops[i], 5'h08, 3'h0, 4);
        chk("ram_wdata", 24'(wex[i]), 24'(rw));
        chk("ram_addr", 24'h000010, 24'(ra));
        chk("ram_rd", 24'h000001, 24'(rds));
        rg(5'h08, mem[i]);
    end
    sw(4'h2, 8'h20);
    op(op_load_and_set, 5'h08, 3'h0, 5);
    ld(5'h09, 8'h5a);
    op(op_push, 5'h09, 3'h0, 2);
    chk("push", 24'h0fff5a, {ra, rw});
    @(posedge sys_clk);
    ram_rdata <= 8'h77;
    op(op_pop, 5'h0a, 3'h0, 4);
    chk("ram_rd", 24'h000001, 24'(rds));
    rg(5'h0a, 8'h77);
    rd(4'h4, 8'hff);
    // stack moved into the internal sram window: one extra cycle each
    sw(4'h5, 8'h20);
    op(op_push, 5'h09, 3'h0, 3);
    chk("push", 24'h20ff5a, {ra, rw});
    op(op_pop, 5'h0b, 3'h0, 5);
    rg(5'h0b, 8'h77);
    ld(5'h00, 8'h34);
    ld(5'h01, 8'h12);
    sw(4'h1, 8'hff);
    sw(4'h2, 8'hff);
    sw(4'h3, 8'h00);
    op(op_program_store, 5'h00, 3'h0, 3);
    chk("prog_wdata", 24'h001234, 24'(pw));
    chk("prog_addr", 24'h00ffff, pa);
    rd(4'h1, 8'h01);
    rd(4'h3, 8'h01);
    $display("t_mem done");
endtask : t_mem
task conclude();
    $display("checked %0d mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
endtask : conclude
initial begin
    #2000000;
    mismatches++;
    conclude();
end
initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rd(4'h5, 8'h0f);
    rd(4'hf, 8'h00);
    t_flags();
    t_shift();
    t_mem();
    conclude();
end
endmodule : cpu_bit_and_memory_ops_tb

// ==== hw/bit_alu.sv ====
// shift, rotate and nibble swap with flag results
`include "core_defines.svh"
module bit_alu
    import core_pkg::*;
(
    input wire logic [7:0] opnd,
    input wire op_t op,
    input wire logic [7:0] flags_in,
    output logic [7:0] res,
    output logic [7:0] flags_out
);
    logic c_out;
    logic h_upd;

    always_comb begin
        res = opnd;
        c_out = flags_in[`FLAG_C];
        h_upd = 1'b0;
        unique case (op)
            op_shift_left_logical: begin
                res = {opnd[6:0], 1'b0};
                c_out = opnd[7];
                h_upd = 1'b1;
            end
            op_shift_right_logical: begin
                res = {1'b0, opnd[7:1]};
                c_out = opnd[0];
            end
            op_shift_right_arith: begin
                res = {opnd[7], opnd[7:1]};
                c_out = opnd[0];
            end
            op_rotate_left_carry: begin
                res = {opnd[6:0], flags_in[`FLAG_C]};
                c_out = opnd[7];
                h_upd = 1'b1;
            end
            op_rotate_right_carry: begin
                res = {flags_in[`FLAG_C], opnd[7:1]};
                c_out = opnd[0];
            end
            op_nibble_swap: begin
                res = {opnd[3:0], opnd[7:4]};
            end
            default: begin
                res = opnd;
            end
        endcase
        flags_out = flags_in;
        if (op != op_nibble_swap) begin
            flags_out[`FLAG_C] = c_out;
            flags_out[`FLAG_Z] = (res == 8'h00);
            flags_out[`FLAG_N] = res[7];
            flags_out[`FLAG_V] = res[7] ^ c_out;
            if (h_upd) begin
                flags_out[`FLAG_H] = opnd[3];
            end
        end
    end
endmodule : bit_alu

// ==== hw/byte_mem.sv ====
// byte-wide memory with registered read data
module byte_mem #(
    parameter int AW = 5
) (
    input wire logic sys_clk,
    mem_if.mem_side m
);
    logic [7:0] cells [2**AW];

    always_ff @(posedge sys_clk) begin
        if (m.we) begin
            cells[m.waddr] <= m.wdata;
        end
    end

    // read before write: same-cycle write shows up one access later
    always_ff @(posedge sys_clk) begin
        m.rdata <= cells[m.raddr];
    end
endmodule : byte_mem

// ==== hw/core_defines.svh ====
// constants of the bit and memory execution unit
// How it works
// - program store writes R1:R0 at extended Z, then Z advances by two
// - I/O read loads destination register in one cycle, flags unchanged
// - push stores register at stack pointer in one cycle, plus SRAM cycle
// - pop loads register from stack in three cycles, plus SRAM cycle
// - load-and-set returns old RAM byte, writes register OR byte
// - load-and-clear returns old RAM byte, writes byte AND NOT register
// - load-and-toggle returns old RAM byte, writes register XOR byte
// - rotate left through carry, updates Z C N V H in one cycle
// - rotate right through carry, updates Z C N V, not H
// - I/O bit set forces one bit high, other bits and flags kept
// - I/O bit clear forces one bit low, other bits and flags kept
// - bit store copies register bit into T, only T changes
// - bit load copies T into register bit, flags unchanged
// - signed flag set and clear touch only S, one cycle
// - overflow flag set and clear touch only V, one cycle
// - half carry set and clear touch only H, one cycle
// - any access to internal SRAM costs one extra cycle
`ifndef CORE_DEFINES_SVH
`define CORE_DEFINES_SVH

// ------------------------------------------------------------
// software register offsets
// ------------------------------------------------------------
`define REG_FLAGS 4'h0
`define REG_Z_LO 4'h1
`define REG_Z_HI 4'h2
`define REG_Z_EXT 4'h3
`define REG_SP_LO 4'h4
`define REG_SP_HI 4'h5
`define REG_STATE 4'h6

// ------------------------------------------------------------
// status flag bit positions
// ------------------------------------------------------------
`define FLAG_C 3'h0
`define FLAG_Z 3'h1
`define FLAG_N 3'h2
`define FLAG_V 3'h3
`define FLAG_S 3'h4
`define FLAG_H 3'h5
`define FLAG_T 3'h6
`define FLAG_I 3'h7

// ------------------------------------------------------------
// reset values and steps
// ------------------------------------------------------------
`define FLAGS_RESET 8'h00
`define Z_RESET 16'h0000
`define Z_EXT_RESET 8'h00
`define SP_RESET 16'h0fff
`define Z_STEP 24'h000002
`define SRAM_LO_DEF 16'h2000
`define SRAM_HI_DEF 16'h2fff

`endif

// ==== hw/core_pkg.sv ====
// types shared by the execution unit modules
package core_pkg;

    typedef enum logic [4:0] {
        op_nop,
        op_program_store,
        op_io_read,
        op_io_write,
        op_push,
        op_pop,
        op_memory_exchange,
        op_load_and_set,
        op_load_and_clear,
        op_load_and_toggle,
        op_shift_left_logical,
        op_shift_right_logical,
        op_shift_right_arith,
        op_rotate_left_carry,
        op_rotate_right_carry,
        op_nibble_swap,
        op_flag_set,
        op_flag_clear,
        op_io_bit_set,
        op_io_bit_clear,
        op_t_flag_store,
        op_t_flag_load
    } op_t;

    typedef enum logic [2:0] {
        st_idle,
        st_exec,
        st_mem,
        st_wait,
        st_data,
        st_ps_hi,
        st_push_wait
    } state_t;

endpackage : core_pkg

// ==== hw/exec_core.sv ====
// bit, shift and memory operation execution unit
//
// Local design decisions: the register addresses and strobed register access.
`include "core_defines.svh"
module exec_core
    import core_pkg::*;
#(
    parameter int RF_AW = 5,
    parameter logic [15:0] SRAM_LO = `SRAM_LO_DEF,
    parameter logic [15:0] SRAM_HI = `SRAM_HI_DEF
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire op_t cmd_op,
    input wire logic [RF_AW-1:0] cmd_reg,
    input wire logic [2:0] cmd_bit,
    input wire logic [5:0] cmd_io,
    output logic cmd_ready,
    output logic cmd_done,
    output logic [15:0] ram_addr,
    output logic ram_rd,
    output logic ram_we,
    output logic [7:0] ram_wdata,
    input wire logic [7:0] ram_rdata,
    output logic [5:0] io_addr,
    output logic io_we,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    output logic [23:0] prog_addr,
    output logic prog_we,
    output logic [15:0] prog_wdata,
    input wire logic [3:0] sw_addr,
    input wire logic [7:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [7:0] sw_rdata
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] put_bit(input logic [7:0] v,
                                           input logic [2:0] b,
                                           input logic val);
        logic [7:0] r;
        r = v;
        r[b] = val;
        return r;
    endfunction : put_bit

    function automatic logic in_sram(input logic [15:0] a);
        return (a >= SRAM_LO) && (a <= SRAM_HI);
    endfunction : in_sram

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    state_t state;
    state_t next_state;
    op_t op;
    logic [RF_AW-1:0] cur_reg;
    logic [2:0] cur_bit;
    logic [7:0] flags;
    logic [7:0] next_flags;
    logic flag_we;
    logic [15:0] z_ptr;
    logic [7:0] z_ext;
    logic [15:0] sp;
    logic [7:0] tmp;
    logic [7:0] opnd;
    logic [7:0] alu_res;
    logic [7:0] alu_flags;
    logic accept;
    logic is_shift;
    logic is_rmw;
    logic [23:0] z_next;

    mem_if #(.AW(RF_AW)) rf ();

    byte_mem #(.AW(RF_AW)) u_rf (
        .sys_clk(sys_clk),
        .m(rf.mem_side)
    );

    bit_alu u_alu (
        .opnd(opnd),
        .op(op),
        .flags_in(flags),
        .res(alu_res),
        .flags_out(alu_flags)
    );

    assign accept = cmd_valid && cmd_ready;
    assign opnd = rf.rdata;
    assign z_next = {z_ext, z_ptr} + `Z_STEP;
    assign is_shift = (op == op_shift_left_logical) ||
                      (op == op_shift_right_logical) ||
                      (op == op_shift_right_arith) ||
                      (op == op_rotate_left_carry) ||
                      (op == op_rotate_right_carry);
    assign is_rmw = (op == op_memory_exchange) || (op == op_load_and_set) ||
                    (op == op_load_and_clear) || (op == op_load_and_toggle);

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            st_idle: begin
                if (accept) begin
                    next_state = st_exec;
                end
            end
            st_exec: begin
                if (op == op_program_store) begin
                    next_state = st_ps_hi;
                end else if (op == op_pop || is_rmw) begin
                    next_state = st_mem;
                end else if (op == op_push && in_sram(sp)) begin
                    next_state = st_push_wait;
                end else begin
                    next_state = st_idle;
                end
            end
            st_mem: begin
                next_state = in_sram(ram_addr) ? st_wait : st_data;
            end
            st_wait: begin
                next_state = st_data;
            end
            st_data: begin
                next_state = st_idle;
            end
            st_ps_hi: begin
                next_state = st_idle;
            end
            st_push_wait: begin
                next_state = st_idle;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= st_idle;
            cmd_ready <= 1'b0;
            cmd_done <= 1'b0;
        end else begin
            state <= next_state;
            cmd_ready <= (next_state == st_idle);
            cmd_done <= (next_state == st_idle) && (state != st_idle);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            op <= op_nop;
            cur_reg <= '0;
            cur_bit <= 3'h0;
            io_addr <= 6'h00;
        end else if (accept) begin
            op <= cmd_op;
            cur_reg <= cmd_reg;
            cur_bit <= cmd_bit;
            io_addr <= cmd_io;
        end
    end

    // ------------------------------------------------------------
    // register file access
    // ------------------------------------------------------------
    always_comb begin
        rf.raddr = cur_reg;
        if (state == st_idle) begin
            rf.raddr = (cmd_op == op_program_store) ? '0 : cmd_reg;
        end else if (state == st_exec && op == op_program_store) begin
            rf.raddr = RF_AW'(1);
        end
        rf.waddr = cur_reg;
        rf.we = 1'b0;
        rf.wdata = opnd;
        if (state == st_exec) begin
            if (op == op_io_read) begin
                rf.we = 1'b1;
                rf.wdata = io_rdata;
            end else if (is_shift || op == op_nibble_swap) begin
                rf.we = 1'b1;
                rf.wdata = alu_res;
            end else if (op == op_t_flag_load) begin
                rf.we = 1'b1;
                rf.wdata = put_bit(opnd, cur_bit, flags[`FLAG_T]);
            end
        end else if (state == st_data) begin
            rf.we = 1'b1;
            rf.wdata = ram_rdata;
        end
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    always_comb begin
        next_flags = flags;
        flag_we = 1'b0;
        if (state == st_exec) begin
            if (is_shift) begin
                flag_we = 1'b1;
                next_flags = alu_flags;
            end else if (op == op_flag_set) begin
                flag_we = 1'b1;
                next_flags = put_bit(flags, cur_bit, 1'b1);
            end else if (op == op_flag_clear) begin
                flag_we = 1'b1;
                next_flags = put_bit(flags, cur_bit, 1'b0);
            end else if (op == op_t_flag_store) begin
                flag_we = 1'b1;
                next_flags = put_bit(flags, `FLAG_T, opnd[cur_bit]);
            end
        end
    end

    // the core's own update beats a software write in the same cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flags <= `FLAGS_RESET;
        end else if (flag_we) begin
            flags <= next_flags;
        end else if (sw_wr && sw_addr == `REG_FLAGS) begin
            flags <= sw_wdata;
        end
    end

    // ------------------------------------------------------------
    // pointers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            z_ptr <= `Z_RESET;
            z_ext <= `Z_EXT_RESET;
        end else if (state == st_ps_hi) begin
            {z_ext, z_ptr} <= z_next;
        end else if (sw_wr) begin
            if (sw_addr == `REG_Z_LO) begin
                z_ptr[7:0] <= sw_wdata;
            end
            if (sw_addr == `REG_Z_HI) begin
                z_ptr[15:8] <= sw_wdata;
            end
            if (sw_addr == `REG_Z_EXT) begin
                z_ext <= sw_wdata;
            end
        end
    end

    // stack grows down: push writes then decrements, pop pre-increments
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sp <= `SP_RESET;
        end else if (state == st_exec && op == op_push) begin
            sp <= sp - 16'h0001;
        end else if (state == st_exec && op == op_pop) begin
            sp <= sp + 16'h0001;
        end else if (sw_wr && sw_addr == `REG_SP_LO) begin
            sp[7:0] <= sw_wdata;
        end else if (sw_wr && sw_addr == `REG_SP_HI) begin
            sp[15:8] <= sw_wdata;
        end
    end

    // ------------------------------------------------------------
    // data memory side
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ram_addr <= 16'h0000;
            ram_rd <= 1'b0;
            ram_we <= 1'b0;
            ram_wdata <= 8'h00;
            tmp <= 8'h00;
        end else begin
            ram_rd <= 1'b0;
            ram_we <= 1'b0;
            if (state == st_exec && op == op_push) begin
                ram_addr <= sp;
                ram_we <= 1'b1;
                ram_wdata <= opnd;
            end else if (state == st_exec && op == op_pop) begin
                ram_addr <= sp + 16'h0001;
                ram_rd <= 1'b1;
            end else if (state == st_exec && is_rmw) begin
                ram_addr <= z_ptr;
                ram_rd <= 1'b1;
                tmp <= opnd;
            end else if (state == st_data && is_rmw) begin
                ram_we <= 1'b1;
                unique case (op)
                    op_load_and_set: ram_wdata <= tmp | ram_rdata;
                    op_load_and_clear: ram_wdata <= ~tmp & ram_rdata;
                    op_load_and_toggle: ram_wdata <= tmp ^ ram_rdata;
                    default: ram_wdata <= tmp;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // I/O and program memory side
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            io_we <= 1'b0;
            io_wdata <= 8'h00;
        end else begin
            io_we <= 1'b0;
            if (state == st_exec) begin
                if (op == op_io_write) begin
                    io_we <= 1'b1;
                    io_wdata <= opnd;
                end else if (op == op_io_bit_set) begin
                    io_we <= 1'b1;
                    io_wdata <= put_bit(io_rdata, cur_bit, 1'b1);
                end else if (op == op_io_bit_clear) begin
                    io_we <= 1'b1;
                    io_wdata <= put_bit(io_rdata, cur_bit, 1'b0);
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prog_we <= 1'b0;
            prog_addr <= 24'h000000;
            prog_wdata <= 16'h0000;
        end else begin
            prog_we <= 1'b0;
            if (state == st_exec && op == op_program_store) begin
                prog_wdata[7:0] <= opnd;
            end else if (state == st_ps_hi) begin
                prog_we <= 1'b1;
                prog_addr <= {z_ext, z_ptr};
                prog_wdata[15:8] <= opnd;
            end
        end
    end

    // ------------------------------------------------------------
    // software read port
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sw_rdata <= 8'h00;
        end else if (sw_rd) begin
            unique case (sw_addr)
                `REG_FLAGS: sw_rdata <= flags;
                `REG_Z_LO: sw_rdata <= z_ptr[7:0];
                `REG_Z_HI: sw_rdata <= z_ptr[15:8];
                `REG_Z_EXT: sw_rdata <= z_ext;
                `REG_SP_LO: sw_rdata <= sp[7:0];
                `REG_SP_HI: sw_rdata <= sp[15:8];
                `REG_STATE: sw_rdata <= {5'h00, state};
                default: sw_rdata <= 8'h00;
            endcase
        end else begin
            sw_rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence exec_of(op_t o);
        state == st_exec && op == o;
    endsequence

    sequence mem_read_path;
        state == st_mem ##1 (state == st_wait || state == st_data);
    endsequence

    chk_ps_pointer: assert property (
        state == st_ps_hi |=> {z_ext, z_ptr} == $past(z_next) && prog_we)
        else $error("program store pointer step wrong");
    chk_io_read_flags: assert property (
        exec_of(op_io_read) |=> $stable(flags) && cmd_done)
        else $error("io read changed flags or overran");
    chk_push_stack: assert property (
        exec_of(op_push) |=> ram_we && ram_addr == $past(sp) &&
            sp == $past(sp) - 16'h0001)
        else $error("push stack write wrong");
    chk_pop_timing: assert property (
        exec_of(op_pop) |=> mem_read_path)
        else $error("pop sequence wrong");
    chk_las_write: assert property (
        state == st_data && op == op_load_and_set |=>
            ram_we && ram_wdata == ($past(tmp) | $past(ram_rdata)))
        else $error("load and set write back wrong");
    chk_lac_write: assert property (
        state == st_data && op == op_load_and_clear |=>
            ram_we && ram_wdata == (~$past(tmp) & $past(ram_rdata)))
        else $error("load and clear write back wrong");
    chk_rol_carry: assert property (
        exec_of(op_rotate_left_carry) |=> flags[`FLAG_C] == $past(opnd[7])
            && flags[`FLAG_H] == $past(opnd[3]))
        else $error("rotate left flags wrong");
    chk_ror_half: assert property (
        exec_of(op_rotate_right_carry) |=> $stable(flags[`FLAG_H]) &&
            flags[`FLAG_C] == $past(opnd[0]))
        else $error("rotate right flags wrong");
    chk_iobit_set: assert property (
        exec_of(op_io_bit_set) |=> io_we && io_wdata[$past(cur_bit)])
        else $error("io bit set missing");
    chk_tstore_only: assert property (
        exec_of(op_t_flag_store) |=> flags[`FLAG_T] == $past(opnd[cur_bit])
            && flags[5:0] == $past(flags[5:0]))
        else $error("bit store touched other flags");
    chk_sram_wait: assert property (
        state == st_mem && in_sram(ram_addr) |=> state == st_wait ##1
            state == st_data)
        else $error("sram extra cycle missing");
endmodule : exec_core

// ==== hw/mem_if.sv ====
// register file port bundle between core and its memory
interface mem_if #(parameter int AW = 5);
    logic [AW-1:0] raddr;
    logic [AW-1:0] waddr;
    logic [7:0] rdata;
    logic [7:0] wdata;
    logic we;
    modport core_side (output raddr, output waddr, output wdata,
                       output we, input rdata);
    modport mem_side (input raddr, input waddr, input wdata,
                      input we, output rdata);
endinterface : mem_if
